// ---- pkg/dlp_regs.vh ----
// constants for the dual loop pid controller
`ifndef DLP_REGS_VH
`define DLP_REGS_VH
// register byte offsets
`define DLP_SEL_OFF        12'h000
`define DLP_CFG_OFF        12'h004
`define DLP_KP_OFF         12'h008
`define DLP_KI_OFF         12'h00C
`define DLP_DA_OFF         12'h010
`define DLP_DB_OFF         12'h014
`define DLP_SETPOINT_OFF   12'h018
`define DLP_OUT_OFF        12'h01C
`define DLP_CTRL_OFF       12'h020
// cfg fields
`define DLP_CFG_TYPE_LO    0
`define DLP_CFG_DUALFN     2
`define DLP_CFG_ACTIVE     3
// loop types
`define DLP_TYPE_SINGLE    2'b00
`define DLP_TYPE_UNI       2'b01
`define DLP_TYPE_BIDIR     2'b10
// sel field: bit 3 picks flow loop coefficients in dual types
`define DLP_SEL_FLOWBIT    3
// timing
`define DLP_CYCLE_MS       500
`define DLP_CLK_KHZ        25000
`define DLP_CYCLE_CLKS     (`DLP_CYCLE_MS * `DLP_CLK_KHZ)
`define DLP_N_FILTER       10
// output full scale, q16.16 of 100 percent
`define DLP_FULL_SCALE     32'h0064_0000
`endif

// ---- design/dlp_mem.v ----
// small coefficient memory with registered read
`timescale 1ns/1ps
module dlp_mem #(
   parameter AW = 4,
   parameter DW = 32
) (
   input  wire          clock_i,
   input  wire          we_i,
   input  wire [AW-1:0] waddr_i,
   input  wire [DW-1:0] wdata_i,
   input  wire [AW-1:0] raddr_i,
   output reg  [DW-1:0] rdata_o
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clock_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule // dlp_mem

// ---- design/dlp_pid.v ----
// one pid step: combinational law, q16.16 signed arithmetic
`timescale 1ns/1ps
`include "dlp_regs.vh"
module dlp_pid (
   input  wire signed [31:0] process_value_i,
   input  wire signed [31:0] setpoint_value_i,
   input  wire signed [31:0] e_prev_i,
   input  wire signed [31:0] ui_prev_i,
   input  wire signed [31:0] ud_prev_i,
   input  wire signed [31:0] kp_i,
   input  wire signed [31:0] ki_i,
   input  wire signed [31:0] da_i,
   input  wire signed [31:0] db_i,
   input  wire               rev_i,
   output wire signed [31:0] e_o,
   output wire signed [31:0] ui_o,
   output wire signed [31:0] ud_o,
   output wire        [31:0] u_o
);
   function signed [31:0] qmul;
      input signed [31:0] a;
      input signed [31:0] b;
      reg   signed [63:0] p;
      begin
         p    = a * b;
         qmul = p[47:16];
      end
   endfunction

   wire signed [31:0] raw_e = process_value_i - setpoint_value_i;
   // reverse action flips the error sign so a positive error lowers output
   assign e_o = rev_i ? -raw_e : raw_e;
   wire signed [31:0] up = qmul(kp_i, e_o);
   // ki holds T*Kp/Ti precomputed for the 0.5 s cycle
   assign ui_o = ui_prev_i + qmul(ki_i, e_o);
   // da = Td/(Td+N*T), db = Td*N*Kp/(Td+N*T)
   assign ud_o = qmul(da_i, ud_prev_i) + qmul(db_i, e_o - e_prev_i);
   wire signed [33:0] sum = {{2{up[31]}}, up} + {{2{ui_o[31]}}, ui_o}
                           + {{2{ud_o[31]}}, ud_o};
   // saturate at 0 and full scale, and hold there while error persists
   assign u_o = sum[33] ? 32'h0000_0000 :
                (sum > $signed({2'b00, `DLP_FULL_SCALE})) ?
                `DLP_FULL_SCALE : sum[31:0];
endmodule // dlp_pid

// ---- design/dlp_ctrl.v ----
// dual loop pid controller top: apb registers, tick, loop sequencer
// What this block does
// - inlet-pressure dual mode: pressure loop acts forward.
// - inlet-pressure dual mode: flow loop acts reverse.
// - both dual outputs computed; the smaller goes to the output.
// - output saturates at full scale and stays while error persists.
// - bidirectional: flow input chosen from the stream of current direction.
// - bidir outlet limiting: second pressure positive, first negative.
// - bidir inlet limiting: first pressure positive, second negative.
// - error is process value minus setpoint of the same cycle.
// - output is sum of P, I, D; P is gain times error.
// - integral adds T times gain over Ti times error each cycle.
// - derivative is first-order filtered with N equal ten.
// - calculation runs every half second; same T in the law.
// - eight independent loops, index first to eighth.
// - loop type single, dual unidirectional or dual bidirectional.
// - dual setting picks outlet or inlet limiting; ignored for single.
// - each loop has an active or inactive status.
// - outlet-pressure dual mode: both loops act reverse.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "dlp_regs.vh"
module dlp_ctrl #(
   parameter LOOPS      = 8,
   parameter CYCLE_CLKS = `DLP_CYCLE_CLKS
) (
   input  wire        clock_i,
   input  wire        rstn_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire [31:0] process_value_i,
   input  wire [31:0] flow_pos_i,
   input  wire [31:0] flow_neg_i,
   input  wire        flow_dir_neg_i,
   input  wire [31:0] first_pressure_input_i,
   input  wire [31:0] second_pressure_input_i,
   output reg  [31:0] loop_out_o,
   output reg  [2:0]  loop_out_idx_o,
   output reg         loop_out_valid_o,
   output reg         cycle_tick_o
);
   localparam S_IDLE  = 4'b0001;
   localparam S_READ  = 4'b0010;
   localparam S_CALC  = 4'b0100;
   localparam S_NEXT  = 4'b1000;

   reg r1, rst_n;
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r1    <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         r1    <= 1'b1;
         rst_n <= r1;
      end
   end

   // per-loop configuration and setpoints
   reg [3:0]  sel;
   reg [3:0]  cfg     [0:LOOPS-1];
   reg [31:0] setpoint_pres[0:LOOPS-1];
   reg [31:0] setpoint_flow[0:LOOPS-1];
   reg [31:0] out_hold[0:LOOPS-1];
   reg [31:0] u_pres_r;
   reg [3:0]  state;
   reg [2:0]  lp;
   reg        half;
   reg [31:0] tick_cnt;
   reg [31:0] next_prdata;
   integer    i;
   integer    j;

   // coefficient memories, one per kind: address {flowloop, loop}
   wire        acc = psel_i & penable_i;
   wire        cwe = acc & pwrite_i & (paddr_i >= `DLP_KP_OFF) &
                     (paddr_i <= `DLP_DB_OFF);
   wire [1:0]  ckind = paddr_i[3:2] - 2'd2;
   wire [31:0] kp_q, ki_q, da_q, db_q;
   wire [3:0]  rd_a = {half, lp};

   dlp_mem #(
      .AW (4),
      .DW (32)
   ) u_kp (
      .clock_i (clock_i),
      .we_i    (cwe & (ckind == 2'd0)),
      .waddr_i (sel),
      .wdata_i (pwdata_i),
      .raddr_i (rd_a),
      .rdata_o (kp_q)
   );

   dlp_mem #(
      .AW (4),
      .DW (32)
   ) u_ki (
      .clock_i (clock_i),
      .we_i    (cwe & (ckind == 2'd1)),
      .waddr_i (sel),
      .wdata_i (pwdata_i),
      .raddr_i (rd_a),
      .rdata_o (ki_q)
   );

   dlp_mem #(
      .AW (4),
      .DW (32)
   ) u_da (
      .clock_i (clock_i),
      .we_i    (cwe & (ckind == 2'd2)),
      .waddr_i (sel),
      .wdata_i (pwdata_i),
      .raddr_i (rd_a),
      .rdata_o (da_q)
   );

   dlp_mem #(
      .AW (4),
      .DW (32)
   ) u_db (
      .clock_i (clock_i),
      .we_i    (cwe & (ckind == 2'd3)),
      .waddr_i (sel),
      .wdata_i (pwdata_i),
      .raddr_i (rd_a),
      .rdata_o (db_q)
   );

   // loop state, indexed like the coefficients
   reg [31:0] e_st  [0:2*LOOPS-1];
   reg [31:0] ui_st [0:2*LOOPS-1];
   reg [31:0] ud_st [0:2*LOOPS-1];

   wire [3:0] c     = cfg[lp];
   wire [1:0] ltype = c[1:0];
   wire       dual  = (ltype != `DLP_TYPE_SINGLE);
   wire       inlet = c[`DLP_CFG_DUALFN];
   wire       bidir = (ltype == `DLP_TYPE_BIDIR);

   // flow input follows direction in bidirectional mode
   wire [31:0] flow_value = bidir ?
      (flow_dir_neg_i ? flow_neg_i : flow_pos_i) : process_value_i;
   // pressure input selection for bidir by function and direction
   wire [31:0] pres_value = !bidir ? first_pressure_input_i :
      (inlet ^ flow_dir_neg_i) ? first_pressure_input_i
                               : second_pressure_input_i;
   wire [31:0] process_value  = !dual ? process_value_i :
                                (half ? flow_value : pres_value);
   wire [31:0] setpoint_value = half ? setpoint_flow[lp] : setpoint_pres[lp];
   // pressure loop forward only in inlet mode; single loop reverse
   wire        rev = !(dual & inlet & !half);
   wire [31:0] e_n, ui_n, ud_n, u_n;

   dlp_pid u_pid (
      .process_value_i  (process_value),
      .setpoint_value_i (setpoint_value),
      .e_prev_i  (e_st[rd_a]),
      .ui_prev_i (ui_st[rd_a]),
      .ud_prev_i (ud_st[rd_a]),
      .kp_i      (kp_q),
      .ki_i      (ki_q),
      .da_i      (da_q),
      .db_i      (db_q),
      .rev_i     (rev),
      .e_o       (e_n),
      .ui_o      (ui_n),
      .ud_o      (ud_n),
      .u_o       (u_n)
   );

   // low selector
   wire [31:0] u_sel = (u_pres_r < u_n) ? u_pres_r : u_n;

   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         state            <= S_IDLE;
         lp               <= 3'd0;
         half             <= 1'b0;
         tick_cnt         <= 32'h0000_0000;
         cycle_tick_o     <= 1'b0;
         loop_out_o       <= 32'h0000_0000;
         loop_out_idx_o   <= 3'd0;
         loop_out_valid_o <= 1'b0;
         u_pres_r         <= 32'h0000_0000;
         for (i = 0; i < 2*LOOPS; i = i + 1) begin
            e_st[i]  <= 32'h0000_0000;
            ui_st[i] <= 32'h0000_0000;
            ud_st[i] <= 32'h0000_0000;
         end
         for (i = 0; i < LOOPS; i = i + 1) begin
            out_hold[i] <= 32'h0000_0000;
         end
      end else begin
         cycle_tick_o     <= 1'b0;
         loop_out_valid_o <= 1'b0;
         if (tick_cnt == CYCLE_CLKS - 1) begin
            tick_cnt     <= 32'h0000_0000;
            cycle_tick_o <= 1'b1;
         end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
         end
         case (state)
            S_IDLE: begin
               if (tick_cnt == CYCLE_CLKS - 1) begin
                  lp    <= 3'd0;
                  half  <= 1'b0;
                  state <= S_READ;
               end
            end
            S_READ: state <= S_CALC;
            S_CALC: begin
               // inactive loops keep state and last output
               if (c[`DLP_CFG_ACTIVE]) begin
                  e_st[rd_a]  <= e_n;
                  ui_st[rd_a] <= ui_n;
                  ud_st[rd_a] <= ud_n;
                  if (dual & !half) begin
                     u_pres_r <= u_n;
                  end else begin
                     out_hold[lp]     <= dual ? u_sel : u_n;
                     loop_out_o       <= dual ? u_sel : u_n;
                     loop_out_idx_o   <= lp;
                     loop_out_valid_o <= 1'b1;
                  end
               end
               state <= S_NEXT;
            end
            S_NEXT: begin
               if (dual & !half) begin
                  half  <= 1'b1;
                  state <= S_READ;
               end else if (lp == LOOPS - 1) begin
                  half  <= 1'b0;
                  state <= S_IDLE;
               end else begin
                  lp    <= lp + 3'd1;
                  half  <= 1'b0;
                  state <= S_READ;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // apb registers: zero wait, unmapped reads zero and errors
   wire mapped = (paddr_i <= `DLP_CTRL_OFF) & (paddr_i[1:0] == 2'b00);
   assign pready_o  = 1'b1;
   assign pslverr_o = acc & ~mapped;
   wire [2:0] sl = sel[2:0];

   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         sel <= 4'h0;
         for (j = 0; j < LOOPS; j = j + 1) begin
            cfg[j]           <= 4'h0;
            setpoint_pres[j] <= 32'h0000_0000;
            setpoint_flow[j] <= 32'h0000_0000;
         end
      end else if (acc & pwrite_i) begin
         if (paddr_i == `DLP_SEL_OFF) begin
            sel <= pwdata_i[3:0];
         end else if (paddr_i == `DLP_CFG_OFF) begin
            cfg[sl] <= pwdata_i[3:0];
         end else if (paddr_i == `DLP_SETPOINT_OFF) begin
            if (sel[`DLP_SEL_FLOWBIT]) begin
               setpoint_flow[sl] <= pwdata_i;
            end else begin
               setpoint_pres[sl] <= pwdata_i;
            end
         end
      end
   end

   always @* begin
      next_prdata = 32'h0000_0000;
      if (paddr_i == `DLP_SEL_OFF) begin
         next_prdata = {28'h000_0000, sel};
      end else if (paddr_i == `DLP_CFG_OFF) begin
         next_prdata = {28'h000_0000, cfg[sl]};
      end else if (paddr_i == `DLP_SETPOINT_OFF) begin
         next_prdata = sel[`DLP_SEL_FLOWBIT] ? setpoint_flow[sl]
                                             : setpoint_pres[sl];
      end else if (paddr_i == `DLP_OUT_OFF) begin
         next_prdata = out_hold[sl];
      end else if (paddr_i == `DLP_CTRL_OFF) begin
         next_prdata = {28'h000_0000, state};
      end
   end

   // read data is caught in the setup phase, so it comes from a flop
   // and stands through the whole access phase with no wait state
   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i & ~penable_i & ~pwrite_i) begin
         prdata_o <= next_prdata;
      end
   end
endmodule // dlp_ctrl

// ---- tb/dlp_ctrl_sva.sv ----
// port assertions for the dual loop controller
`timescale 1ns/1ps
module dlp_ctrl_sva #(
   parameter CYCLE_CLKS = 60
) (
   input wire        clock_i,
   input wire        rstn_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire [11:0] paddr_i,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire [31:0] loop_out_o,
   input wire [2:0]  loop_out_idx_o,
   input wire        loop_out_valid_o,
   input wire        cycle_tick_o
);
   int   gap;
   logic seen;
   wire  acc = psel_i && penable_i;
   wire  bad = paddr_i > 12'h020 || paddr_i[1:0] != 2'b00;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // clocks since the last calculation tick
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gap  <= 0;
         seen <= 1'b0;
      end else begin
         gap  <= cycle_tick_o ? 1 : gap + 1;
         seen <= seen | cycle_tick_o;
      end
   end
   pready_high_a: assert property (pready_o)
      else $error("pready low");
   slverr_decode_a: assert property (acc |-> pslverr_o == bad)
      else $error("slave error does not match address");
   slverr_idle_a: assert property (!acc |-> !pslverr_o)
      else $error("slave error outside access phase");
   tick_period_a: assert property (
      seen && cycle_tick_o |-> gap == CYCLE_CLKS) else $error("bad period");
   tick_gap_a: assert property (seen |-> gap <= CYCLE_CLKS)
      else $error("tick missing");
   out_window_a: assert property (
      loop_out_valid_o |-> seen && gap <= 49) else $error("late output");
   out_pulse_a: assert property (loop_out_valid_o |=> !loop_out_valid_o)
      else $error("output pulse too long");
   out_clamp_a: assert property (
      loop_out_valid_o |-> loop_out_o <= 32'h0064_0000) else $error("clamp");
   out_hold_a: assert property (!loop_out_valid_o |->
      $stable(loop_out_o) && $stable(loop_out_idx_o)) else $error("drift");
endmodule // dlp_ctrl_sva

bind dlp_ctrl dlp_ctrl_sva #(.CYCLE_CLKS(CYCLE_CLKS)) chk_u (
   .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i),
   .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .loop_out_o(loop_out_o),
   .loop_out_idx_o(loop_out_idx_o), .loop_out_valid_o(loop_out_valid_o),
   .cycle_tick_o(cycle_tick_o));

// ---- tb/dlp_plant.sv ----
// far side model: process measurements and valve drive
`timescale 1ns/1ps
module dlp_plant (
   input  wire         clock_i,
   input  wire  [31:0] loop_out_i,
   input  wire         loop_out_valid_i,
   output logic [31:0] process_value_o,
   output logic [31:0] flow_pos_o,
   output logic [31:0] flow_neg_o,
   output logic        flow_dir_neg_o,
   output logic [31:0] first_pressure_input_o,
   output logic [31:0] second_pressure_input_o,
   output logic [31:0] valve_o
);
   // valve follows each new controller output
   always @(posedge clock_i) begin
      if (loop_out_valid_i) valve_o <= loop_out_i;
   end
   // whole units in, q16.16 out; called just after a clock edge
   task automatic apply(input int proc, fp, fn, dn, pres_a, pres_b);
      process_value_o         <= proc << 16;
      flow_pos_o              <= fp << 16;
      flow_neg_o              <= fn << 16;
      flow_dir_neg_o          <= dn[0];
      first_pressure_input_o  <= pres_a << 16;
      second_pressure_input_o <= pres_b << 16;
   endtask
endmodule // dlp_plant

// ---- tb/dlp_ctrl_tb_top.sv ----
// self-checking bench for the dual loop controller
`timescale 1ns/1ps
`include "dlp_regs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   failures++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module dlp_ctrl_tb_top;
   logic        clock_i, rstn_i, psel, pen, pwr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd, got;
   wire  [31:0] prdata, process_value, fp, fn, lo, valve;
   wire  [31:0] first_pressure_input, second_pressure_input;
   wire         pready, pslverr, dn, lval, tick;
   wire  [2:0]  lidx;
   int          failures = 0;
   int          comparisons = 0;
   // loop, cfg, process value, flow+, flow-, neg dir, pressure a, pressure b,
   // expected output
   int rows[12][9] = '{'{0,12,10,0,0,0,0,0,20}, '{3,9,10,0,0,0,58,0,2},
      '{3,9,10,0,0,0,30,0,20}, '{3,13,10,0,0,0,62,0,2},
      '{3,13,10,0,0,0,58,0,0}, '{3,13,10,0,0,0,90,0,20},
      '{7,10,0,10,12,0,45,50,10}, '{7,10,0,10,12,1,45,50,15},
      '{7,10,0,25,10,0,45,50,5}, '{7,10,0,10,28,1,45,50,2},
      '{7,14,0,10,10,0,65,75,5}, '{7,14,0,10,10,1,65,75,15}};
   dlp_ctrl #(.CYCLE_CLKS(60)) dut_u (.clock_i(clock_i), .rstn_i(rstn_i),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .process_value_i(process_value),
      .flow_pos_i(fp), .flow_neg_i(fn), .flow_dir_neg_i(dn),
      .first_pressure_input_i(first_pressure_input),
      .second_pressure_input_i(second_pressure_input), .loop_out_o(lo),
      .loop_out_idx_o(lidx), .loop_out_valid_o(lval), .cycle_tick_o(tick));
   dlp_plant plant_u (.clock_i(clock_i), .loop_out_i(lo),
      .loop_out_valid_i(lval), .process_value_o(process_value),
      .flow_pos_o(fp), .flow_neg_o(fn), .flow_dir_neg_o(dn),
      .first_pressure_input_o(first_pressure_input),
      .second_pressure_input_o(second_pressure_input), .valve_o(valve));
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock_i);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 16) begin
         `CHK("bus wait", 1'b1, 1'b0)
         finish_test();
      end
   endtask
   task automatic coef(input logic [3:0] s, input logic [31:0] kp, ki,
                       da, db, input int setp);
      bus(1'b1, `DLP_SEL_OFF, {28'h0, s});
      bus(1'b1, `DLP_KP_OFF, kp);
      bus(1'b1, `DLP_KI_OFF, ki);
      bus(1'b1, `DLP_DA_OFF, da);
      bus(1'b1, `DLP_DB_OFF, db);
      bus(1'b1, `DLP_SETPOINT_OFF, 32'(setp << 16));
   endtask
   task automatic mode(input logic [2:0] i, input logic [31:0] c);
      bus(1'b1, `DLP_SEL_OFF, {29'h0, i});
      bus(1'b1, `DLP_CFG_OFF, c);
   endtask
   task automatic wout(input logic [2:0] i);
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (!(lval === 1'b1 && lidx === i) && n < 400);
      got = lo;
      if (n >= 400) begin
         failures++;
         finish_test();
      end
   endtask
   task automatic t_pid();
      int n;
      bus(1'b0, 12'h024, 32'h0000_0000);
      `CHK("unmapped error", 1'b1, err)
      plant_u.apply(10, 0, 0, 0, 0, 0);
      coef(4'h1, 32'h0001_0000, 32'h0000_8000, 0, 0, 30);
      mode(3'd1, 32'h0000_0008);
      for (int k = 1; k <= 10; k++) begin
         wout(3'd1);
         `CHK("integral", 32'((k < 8 ? 20 + 10 * k : 100) << 16), got)
      end
      mode(3'd1, 32'h0000_0000);
      plant_u.apply(50, 0, 0, 0, 0, 0);
      n = 0;
      repeat (150) begin
         @(posedge clock_i);
         if (lval === 1'b1 && lidx === 3'd1) n++;
      end
      `CHK("inactive pulses", 0, n)
      bus(1'b0, `DLP_OUT_OFF, 32'h0000_0000);
      `CHK("held output", 32'h0064_0000, rd)
      plant_u.apply(30, 0, 0, 0, 0, 0);
      mode(3'd1, 32'h0000_0008);
      wout(3'd1);
      `CHK("frozen integral", 32'h0064_0000, got)
      plant_u.apply(10, 0, 0, 0, 0, 0);
      coef(4'h2, 0, 0, 32'h0000_8000, 32'h0001_0000, 30);
      mode(3'd2, 32'h0000_0008);
      for (int k = 0; k < 4; k++) begin
         wout(3'd2);
         `CHK("derivative", 32'h0014_0000 >> k, got)
      end
      $display("test pid done");
   endtask
   task automatic t_dual();
      coef(4'h0, 32'h0001_0000, 0, 0, 0, 30);
      coef(4'h3, 32'h0001_0000, 0, 0, 0, 60);
      coef(4'hB, 32'h0001_0000, 0, 0, 0, 30);
      coef(4'h7, 32'h0001_0000, 0, 0, 0, 60);
      coef(4'hF, 32'h0001_0000, 0, 0, 0, 30);
      foreach (rows[r]) begin
         plant_u.apply(rows[r][2], rows[r][3], rows[r][4], rows[r][5],
                       rows[r][6], rows[r][7]);
         mode(3'(rows[r][0]), 32'(rows[r][1]));
         repeat (2) wout(3'(rows[r][0]));
         `CHK("loop select", 32'(rows[r][8] << 16), got)
         @(posedge clock_i);
         `CHK("valve drive", 32'(rows[r][8] << 16), valve)
      end
      $display("test dual done");
   endtask
   initial begin
      rstn_i = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      plant_u.apply(0, 0, 0, 0, 0, 0);
      repeat (12) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      t_pid();
      t_dual();
      finish_test();
   end
endmodule // dlp_ctrl_tb_top
